// ==== src/bdio_pkg.sv ====
package bdio_pkg;

  // Port widths
  localparam int P0_W = 3;
  localparam int P1_W = 4;

  // Register byte offsets (APB, one aligned word each)
  localparam logic [7:0] OFF_LATCH0  = 8'h00;
  localparam logic [7:0] OFF_DIR0    = 8'h04;
  localparam logic [7:0] OFF_PULLUP0 = 8'h08;
  localparam logic [7:0] OFF_LATCH1  = 8'h10;
  localparam logic [7:0] OFF_DIR1    = 8'h14;
  localparam logic [7:0] OFF_PULLUP1 = 8'h18;
  localparam logic [7:0] OFF_ALTEN   = 8'h20;
  localparam logic [7:0] OFF_SERCTL  = 8'h24;

  // Reset values: direction 1 = input
  localparam logic [P0_W-1:0] DIR0_RST = 3'h7;
  localparam logic [P1_W-1:0] DIR1_RST = 4'hf;
  localparam logic [P0_W-1:0] ZERO0    = 3'h0;
  localparam logic [P1_W-1:0] ZERO1    = 4'h0;

  // Alternate-enable field layout (bits 2:0 port 0, bits 6:4 port 1 outputs)
  localparam int ALT0_LSB  = 0;
  localparam int ALT1_LSB  = 4;
  // Serial control: transmit output level bit
  localparam int TXLV_BIT  = 0;

  // Pin-side carrier for one port
  typedef struct packed {
    logic [P1_W-1:0] out;
    logic [P1_W-1:0] oe;
    logic [P1_W-1:0] pu;
  } bdio_pins_s;

  // Whole register state
  typedef struct packed {
    logic [P0_W-1:0] latch0;
    logic [P0_W-1:0] dir0;
    logic [P0_W-1:0] pu0;
    logic [P1_W-1:0] latch1;
    logic [P1_W-1:0] dir1;
    logic [P1_W-1:0] pu1;
    logic [P0_W-1:0] alt0;
    logic [2:0]      alt1;
    logic            txlv;
    logic [P0_W-1:0] sync0_a;
    logic [P0_W-1:0] sync0_b;
    logic [P1_W-1:0] sync1_a;
    logic [P1_W-1:0] sync1_b;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic [P0_W-1:0] out0;
    logic [P0_W-1:0] oe0;
    logic [P0_W-1:0] pue0;
    logic [P1_W-1:0] out1;
    logic [P1_W-1:0] oe1;
    logic [P1_W-1:0] pue1;
  } bdio_state_s;

endpackage

// ==== src/bdio_ports.sv ====
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// RULE1: Port 0 pins have latch, per-bit direction
// RULE2: Port 0 per-bit pull-up, input mode only
// RULE3: Reset puts all port 0 pins input
// RULE4: Port 0 carries interrupt and timer functions
// RULE5: Port 1 pins have latch, per-bit direction
// RULE6: Port 1 per-bit pull-up while input
// RULE7: Reset puts all port 1 pins input
// RULE8: Port 1 carries irq, serial, timer functions
// RULE9: Software clears tx level before GPIO use
// RULE10: Read gives pin when input, latch otherwise
module bdio_ports (
  input  wire logic                      I_MCLK,
  input  wire logic                      I_RST_B,
  input  wire logic                      I_PSEL,
  input  wire logic                      I_PENABLE,
  input  wire logic                      I_PWRITE,
  input  wire logic [7:0]                I_PADDR,
  input  wire logic [31:0]               I_PWDATA,
  input  wire logic [3:0]                I_PSTRB,
  output logic      [31:0]               O_PRDATA,
  output logic                           O_PREADY,
  output logic                           O_PSLVERR,
  input  wire logic [bdio_pkg::P0_W-1:0] I_P0_PIN,
  output logic      [bdio_pkg::P0_W-1:0] O_P0_OUT,
  output logic      [bdio_pkg::P0_W-1:0] O_P0_OE,
  output logic      [bdio_pkg::P0_W-1:0] O_P0_PU,
  input  wire logic [bdio_pkg::P1_W-1:0] I_P1_PIN,
  output logic      [bdio_pkg::P1_W-1:0] O_P1_OUT,
  output logic      [bdio_pkg::P1_W-1:0] O_P1_OE,
  output logic      [bdio_pkg::P1_W-1:0] O_P1_PU,
  input  wire logic [bdio_pkg::P0_W-1:0] I_ALT0_OUT,
  input  wire logic [2:0]                I_ALT1_OUT,
  input  wire logic                      I_SER_TX,
  output logic      [bdio_pkg::P0_W-1:0] O_ALT0_IN,
  output logic      [bdio_pkg::P1_W-1:0] O_ALT1_IN,
  output logic                           O_TX_LEVEL
);

  // Register state and its next value
  bdio_pkg::bdio_state_s     s_r;
  bdio_pkg::bdio_state_s     s_nxt;
  // Bus decode
  logic                      acc;
  logic                      wr_en;
  logic                      rd_en;
  logic                      hit;
  logic                      wr_ok;
  logic                      we_latch0;
  logic                      we_dir0;
  logic                      we_pu0;
  logic                      we_latch1;
  logic                      we_dir1;
  logic                      we_pu1;
  logic                      we_alten;
  logic                      we_serctl;
  logic [31:0]               rd_val;
  // Pin-side helpers
  logic [3:0]                alt_o1;
  logic [3:0]                drv1;
  logic [3:0]                ser_tx_lv;
  logic [bdio_pkg::P0_W-1:0] view0;
  logic [bdio_pkg::P0_W-1:0] drive0;
  logic [bdio_pkg::P1_W-1:0] view1;
  logic [bdio_pkg::P1_W-1:0] drive1;

  // Access phase, first cycle only; ready follows one cycle later
  assign acc   = I_PSEL & I_PENABLE & ~s_r.pready;
  assign wr_en = acc & I_PWRITE;
  assign rd_en = acc & ~I_PWRITE;
  // Writes use the low byte lane; a cleared strobe leaves state alone
  assign wr_ok = wr_en & hit & I_PSTRB[0];

  // One write strobe per register
  assign we_latch0 = wr_ok & (I_PADDR == bdio_pkg::OFF_LATCH0);
  assign we_dir0   = wr_ok & (I_PADDR == bdio_pkg::OFF_DIR0);
  assign we_pu0    = wr_ok & (I_PADDR == bdio_pkg::OFF_PULLUP0);
  assign we_latch1 = wr_ok & (I_PADDR == bdio_pkg::OFF_LATCH1);
  assign we_dir1   = wr_ok & (I_PADDR == bdio_pkg::OFF_DIR1);
  assign we_pu1    = wr_ok & (I_PADDR == bdio_pkg::OFF_PULLUP1);
  assign we_alten  = wr_ok & (I_PADDR == bdio_pkg::OFF_ALTEN);
  assign we_serctl = wr_ok & (I_PADDR == bdio_pkg::OFF_SERCTL);

  // Serial transmit level acts on the serial path only
  assign ser_tx_lv = {3'h0, I_SER_TX ^ s_r.txlv};
  // Port 1 alternate outputs: pin 0 serial, pins 1 to 3 timers
  assign alt_o1    = {I_ALT1_OUT[2:1], I_ALT1_OUT[0], 1'b0} | ser_tx_lv;        // RULE8
  // Port 1 alternate selects: enable bit 0 claims pins 0 and 1
  assign drv1      = {s_r.alt1, 1'b0} | {3'h0, s_r.alt1[0]};                   // RULE8

  // Per-bit views of port 0: read value and pin drive
  for (genvar b = 0; b < bdio_pkg::P0_W; b++) begin : g_bit0
    // Input bits read the synchronised pin, output bits the latch
    assign view0[b]  = s_r.dir0[b] ? s_r.sync0_b[b] : s_r.latch0[b];          // RULE10
    // Enabled alternate output replaces the latch as pin level; direction still sets the enable
    assign drive0[b] = s_r.alt0[b] ? I_ALT0_OUT[b] : s_r.latch0[b];           // RULE1 RULE4
  end

  // Per-bit views of port 1: read value and pin drive
  for (genvar b = 0; b < bdio_pkg::P1_W; b++) begin : g_bit1
    // Input bits read the synchronised pin, output bits the latch
    assign view1[b]  = s_r.dir1[b] ? s_r.sync1_b[b] : s_r.latch1[b];          // RULE10
    // Enabled alternate output replaces the latch as pin level; direction still sets the enable
    assign drive1[b] = drv1[b] ? alt_o1[b] : s_r.latch1[b];                   // RULE5 RULE8
  end

  // Register read mux; unmapped addresses answer with an error
  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0;
    unique case (I_PADDR)
      // Port 0 registers
      bdio_pkg::OFF_LATCH0:  rd_val[bdio_pkg::P0_W-1:0] = view0;              // RULE10
      bdio_pkg::OFF_DIR0:    rd_val[bdio_pkg::P0_W-1:0] = s_r.dir0;
      bdio_pkg::OFF_PULLUP0: rd_val[bdio_pkg::P0_W-1:0] = s_r.pu0;
      // Port 1 registers
      bdio_pkg::OFF_LATCH1:  rd_val[bdio_pkg::P1_W-1:0] = view1;              // RULE10
      bdio_pkg::OFF_DIR1:    rd_val[bdio_pkg::P1_W-1:0] = s_r.dir1;
      bdio_pkg::OFF_PULLUP1: rd_val[bdio_pkg::P1_W-1:0] = s_r.pu1;
      // Shared control registers
      bdio_pkg::OFF_ALTEN: begin
        rd_val[bdio_pkg::ALT0_LSB +: bdio_pkg::P0_W] = s_r.alt0;
        rd_val[bdio_pkg::ALT1_LSB +: 3]              = s_r.alt1;
      end
      bdio_pkg::OFF_SERCTL:  rd_val[bdio_pkg::TXLV_BIT] = s_r.txlv;
      default:               hit = 1'b0;
    endcase
  end

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    // Two-flop pin synchronisers; only the second flop is read
    s_nxt.sync0_a = I_P0_PIN;
    s_nxt.sync0_b = s_r.sync0_a;
    s_nxt.sync1_a = I_P1_PIN;
    s_nxt.sync1_b = s_r.sync1_a;

    // Ready and error answer one cycle after the access is taken
    s_nxt.pready  = I_PSEL & I_PENABLE & ~s_r.pready;
    s_nxt.pslverr = (wr_en | rd_en) & ~hit;
    // Read data holds until the next read
    if (rd_en) begin
      s_nxt.prdata = rd_val;
    end

    // Port 0 registers
    if (we_latch0) begin
      s_nxt.latch0 = I_PWDATA[bdio_pkg::P0_W-1:0];                            // RULE10
    end
    if (we_dir0) begin
      s_nxt.dir0 = I_PWDATA[bdio_pkg::P0_W-1:0];                              // RULE1
    end
    if (we_pu0) begin
      s_nxt.pu0 = I_PWDATA[bdio_pkg::P0_W-1:0];                               // RULE2
    end

    // Port 1 registers
    if (we_latch1) begin
      s_nxt.latch1 = I_PWDATA[bdio_pkg::P1_W-1:0];                            // RULE10
    end
    if (we_dir1) begin
      s_nxt.dir1 = I_PWDATA[bdio_pkg::P1_W-1:0];                              // RULE5
    end
    if (we_pu1) begin
      s_nxt.pu1 = I_PWDATA[bdio_pkg::P1_W-1:0];                               // RULE6
    end

    // Alternate enables and serial control
    if (we_alten) begin
      s_nxt.alt0 = I_PWDATA[bdio_pkg::ALT0_LSB +: bdio_pkg::P0_W];            // RULE4
      s_nxt.alt1 = I_PWDATA[bdio_pkg::ALT1_LSB +: 3];                         // RULE8
    end
    if (we_serctl) begin
      s_nxt.txlv = I_PWDATA[bdio_pkg::TXLV_BIT];
    end

    // Port 0 pin drive; pull-up only while input
    s_nxt.out0 = drive0;                                                      // RULE1 RULE4
    s_nxt.oe0  = ~s_r.dir0;                                                   // RULE1
    s_nxt.pue0 = s_r.pu0 & s_r.dir0;                                          // RULE2
    // Port 1 pin drive; pull-up only while input
    s_nxt.out1 = drive1;                                                      // RULE5 RULE8
    s_nxt.oe1  = ~s_r.dir1;                                                   // RULE5
    s_nxt.pue1 = s_r.pu1 & s_r.dir1;                                          // RULE6
  end

  // State register; reset leaves every pin an input
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      // Clear everything, then mark every pin an input
      s_r        <= '0;
      s_r.dir0   <= bdio_pkg::DIR0_RST;                                       // RULE3
      s_r.dir1   <= bdio_pkg::DIR1_RST;                                       // RULE7
      // Drivers stay off until software picks output mode
      s_r.oe0    <= bdio_pkg::ZERO0;                                          // RULE3
      s_r.oe1    <= bdio_pkg::ZERO1;                                          // RULE7
    end else begin
      s_r <= s_nxt;
    end
  end

  // Bus answer straight from flops
  assign O_PRDATA   = s_r.prdata;
  assign O_PREADY   = s_r.pready;
  assign O_PSLVERR  = s_r.pslverr;

  // Port 0 pins
  assign O_P0_OUT   = s_r.out0;
  assign O_P0_OE    = s_r.oe0;
  assign O_P0_PU    = s_r.pue0;

  // Port 1 pins
  assign O_P1_OUT   = s_r.out1;
  assign O_P1_OE    = s_r.oe1;
  assign O_P1_PU    = s_r.pue1;

  // Peripheral side: synchronised pin levels and tx level
  assign O_ALT0_IN  = s_r.sync0_b;                                            // RULE4
  assign O_ALT1_IN  = s_r.sync1_b;                                            // RULE8
  assign O_TX_LEVEL = s_r.txlv;

endmodule // bdio_ports

// ==== testbench/bdio_ports_monitor.sv ====
`timescale 1ns/1ps
module bdio_ports_monitor (
  input wire logic                      I_MCLK,
  input wire logic                      I_RST_B,
  input wire logic                      I_PSEL,
  input wire logic                      I_PENABLE,
  input wire logic                      I_PWRITE,
  input wire logic [7:0]                I_PADDR,
  input wire logic [31:0]               I_PWDATA,
  input wire logic [3:0]                I_PSTRB,
  input wire logic                      O_PREADY,
  input wire logic                      O_PSLVERR,
  input wire logic [bdio_pkg::P0_W-1:0] O_P0_OE,
  input wire logic [bdio_pkg::P0_W-1:0] O_P0_PU,
  input wire logic [bdio_pkg::P1_W-1:0] O_P1_OE,
  input wire logic [bdio_pkg::P1_W-1:0] O_P1_PU
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);
  // Completed direction writes reach the output enables
  property p_dir0;
    I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == bdio_pkg::OFF_DIR0 && I_PSTRB[0]
      |=> O_P0_OE == ~$past(I_PWDATA[2:0]);
  endproperty
  property p_dir1;
    I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == bdio_pkg::OFF_DIR1 && I_PSTRB[0]
      |=> O_P1_OE == ~$past(I_PWDATA[3:0]);
  endproperty
  a_dir0_oe: assert property (p_dir0) else $error("port 0 enable not set by write");
  a_dir1_oe: assert property (p_dir1) else $error("port 1 enable not set by write");
  a_pu0_input: assert property ((O_P0_PU & O_P0_OE) == 3'h0) else $error("port 0 pull-up on output");
  a_pu1_input: assert property ((O_P1_PU & O_P1_OE) == 4'h0) else $error("port 1 pull-up on output");
  a_reset_input: assert property ($rose(I_RST_B) |-> O_P0_OE == 3'h0 && O_P1_OE == 4'h0)
    else $error("pins not input after reset");
  a_ready_wait: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (O_PREADY |=> !O_PREADY) else $error("ready longer than one cycle");
  a_err_ready: assert property (O_PSLVERR |-> O_PREADY) else $error("error without ready");
  // Main scenarios
  cover property (O_PSLVERR);
  cover property (O_P0_PU != 3'h0);
  cover property (O_P1_OE != 4'h0);
endmodule // bdio_ports_monitor
bind bdio_ports bdio_ports_monitor bdio_ports_monitor_inst (.I_MCLK, .I_RST_B, .I_PSEL, .I_PENABLE, .I_PWRITE,
  .I_PADDR, .I_PWDATA, .I_PSTRB, .O_PREADY, .O_PSLVERR, .O_P0_OE, .O_P0_PU, .O_P1_OE, .O_P1_PU);

// ==== testbench/bdio_ports_tb.sv ====
`timescale 1ns/1ps
module bdio_ports_tb;
  logic        clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, err;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h0, rd, prd;
  logic [2:0]  p0pin = 3'h0, p0out, p0oe, p0pu;
  logic [3:0]  p1pin = 4'h0, p1out, p1oe, p1pu;
  logic        rdy, slverr, ser = 1'b0, txl;
  logic [2:0]  alt0o = 3'h0, alt1o = 3'h0, a0in;
  logic [3:0]  pstb = 4'hf, a1in;
  int          failures = 0, num_checks = 0, i;
  // Rows: address, write data, expected read back
  logic [7:0]  ra[8] = '{8'h04, 8'h08, 8'h14, 8'h18, 8'h00, 8'h10, 8'h24, 8'h24};
  logic [31:0] rw[8] = '{32'h5, 32'h7, 32'ha, 32'hf, 32'h7, 32'hf, 32'h1, 32'h0};
  logic [31:0] re[8] = '{32'h5, 32'h7, 32'ha, 32'hf, 32'h2, 32'h5, 32'h1, 32'h0};
  bdio_ports bdio_ports_inst (.I_MCLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(padr), .I_PWDATA(pwd), .I_PSTRB(pstb), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(slverr),
    .I_P0_PIN(p0pin), .O_P0_OUT(p0out), .O_P0_OE(p0oe), .O_P0_PU(p0pu), .I_P1_PIN(p1pin), .O_P1_OUT(p1out),
    .O_P1_OE(p1oe), .O_P1_PU(p1pu), .I_ALT0_OUT(alt0o), .I_ALT1_OUT(alt1o), .I_SER_TX(ser), .O_ALT0_IN(a0in),
    .O_ALT1_IN(a1in), .O_TX_LEVEL(txl));
  // Clock at 200 MHz
  always #2.5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; padr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Only the watchdog ends a wait for ready
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    err = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #20000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk("oe0 reset", 32'h0, {29'h0, p0oe});
    apb(0, bdio_pkg::OFF_DIR0, 0); chk("dir0 reset", 32'h7, rd);
    apb(0, bdio_pkg::OFF_DIR1, 0); chk("dir1 reset", 32'hf, rd);
    $display("reset test done");
    for (i = 0; i < 8; i++) begin
      apb(1, ra[i], rw[i]);
      apb(0, ra[i], 0);
      chk("readback", re[i], rd);
    end
    $display("row test done");
    chk("oe0", 32'h2, {29'h0, p0oe});
    chk("pu0", 32'h5, {29'h0, p0pu});
    chk("out0", 32'h2, {29'h0, p0out & p0oe});
    chk("oe1", 32'h5, {28'h0, p1oe});
    chk("pu1", 32'ha, {28'h0, p1pu});
    chk("out1", 32'h5, {28'h0, p1out & p1oe});
    p0pin <= 3'h5;
    apb(0, bdio_pkg::OFF_LATCH0, 0); chk("pin0 read", 32'h7, rd);
    apb(0, 8'h30, 0); chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("pin and error test done");
    // Cleared strobe leaves the direction register alone
    pstb <= 4'h0;
    apb(1, bdio_pkg::OFF_DIR0, 32'h0);
    pstb <= 4'hf;
    apb(0, bdio_pkg::OFF_DIR0, 0); chk("strobe off", 32'h5, rd);
    // Alternate functions: port 0 pin 1 timer, port 1 pins 0 and 1 serial and timer
    alt0o <= 3'h5; alt1o <= 3'h6; ser <= 1'b1; p1pin <= 4'h9;
    apb(1, bdio_pkg::OFF_ALTEN, 32'h12);
    @(posedge clk);
    chk("alt out0", 32'h5, {29'h0, p0out});
    chk("alt out1", 32'hd, {28'h0, p1out});
    chk("alt in0", 32'h5, {29'h0, a0in});
    chk("alt in1", 32'h9, {28'h0, a1in});
    apb(1, bdio_pkg::OFF_SERCTL, 32'h1);
    @(posedge clk);
    chk("tx inverted", 32'hc, {28'h0, p1out});
    chk("tx level", 32'h1, {31'h0, txl});
    apb(1, bdio_pkg::OFF_SERCTL, 32'h0);
    apb(1, bdio_pkg::OFF_ALTEN, 32'h0);
    @(posedge clk);
    chk("tx level clear", 32'h0, {31'h0, txl});
    chk("gpio out1", 32'hf, {28'h0, p1out});
    $display("alternate function test done");
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    chk("oe1 mid reset", 32'h0, {28'h0, p1oe});
    apb(0, bdio_pkg::OFF_DIR1, 0); chk("dir1 mid reset", 32'hf, rd);
    $display("second reset test done");
    print_verdict();
  end
endmodule // bdio_ports_tb
